// ---- hw/aclink_bank_pkg.sv ----
// Shared constants for the codec-side register bank on the serial audio link.
// Assumes a single 20 MHz system clock; link pins are sampled, never used as clocks.
`default_nettype none

package aclink_bank_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 7;
  localparam int IDX_W = 6;
  localparam int RAM_WORDS = 64;

  typedef logic [DATA_W-1:0] word_t;
  typedef logic [ADDR_W-1:0] reg_addr_t;
  typedef logic [IDX_W-1:0] reg_idx_t;

  // Byte offsets on the link
  localparam reg_addr_t ADDR_SW_RESET = 7'h00;
  localparam reg_addr_t ADDR_POWERDOWN = 7'h26;
  localparam reg_addr_t ADDR_EXT_AUDIO_CAP = 7'h28;
  localparam reg_addr_t ADDR_FRONT_RATE = 7'h2C;
  localparam reg_addr_t ADDR_SURROUND_RATE = 7'h2E;
  localparam reg_addr_t ADDR_LFE_RATE = 7'h30;
  localparam reg_addr_t ADDR_FIXED_RATE0 = 7'h32;
  localparam reg_addr_t ADDR_FIXED_RATE1 = 7'h34;
  localparam reg_addr_t ADDR_EXT_MODEM_CAP = 7'h3C;
  localparam reg_addr_t ADDR_VENDOR_CFG = 7'h6A;
  localparam reg_addr_t ADDR_VENDOR_ID1 = 7'h7C;
  localparam reg_addr_t ADDR_VENDOR_ID2 = 7'h7E;

  // Field positions
  localparam int CODEC_INDEX_BIT0_POS = 14;
  localparam int CODEC_INDEX_BIT1_POS = 15;
  localparam int LINK_SILENCE_POS = 12;
  localparam int FULL_COMPLIANCE_POS = 0;

  // Reset values of mirrored flip-flops
  localparam logic SILENCE_RESET = 1'b0;
  localparam logic RATE_FLAG_RESET = 1'b0;
  localparam logic FULL_COMPLIANCE_RESET = 1'b1;

  localparam word_t RATE_48K = 16'hBB80;
  localparam word_t RATE_44K = 16'hAC44;

  // Frame layout, bit positions counted from the first bit of slot 0
  localparam int SLOT0_W = 16;
  localparam int SLOT_W = 20;
  localparam logic [7:0] SLOT0_LAST = 8'h0F;
  localparam logic [7:0] SLOT1_LAST = 8'h23;
  localparam logic [7:0] SLOT2_LAST = 8'h37;
  localparam int TAG_FRAME_POS = 15;
  localparam int TAG_SLOT1_POS = 14;
  localparam int TAG_SLOT2_POS = 13;
  localparam int CMD_READ_POS = 19;
  localparam int CMD_ADDR_HI = 18;
  localparam int CMD_ADDR_LO = 12;
  localparam int DATA_LSB = 4;

  // Warm reset: sync held high with no bit clock edge for at least this long
  localparam int CLK_PERIOD_NS = 50;
  localparam int WARM_RESET_NS = 1000;
  localparam int WARM_RESET_CYC = (WARM_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bits kept on a link read in full-compliance mode; cleared bits are reserved
  function automatic word_t read_keep_mask(input reg_addr_t a);
    word_t m;
    m = 16'hFFFF;
    case (a)
      ADDR_POWERDOWN: m = 16'hFF0F;
      ADDR_EXT_AUDIO_CAP: m = 16'hCFFF;
      ADDR_EXT_MODEM_CAP: m = 16'hCFFF;
      ADDR_VENDOR_CFG: m = 16'h0001;
      default: m = 16'hFFFF;
    endcase
    return m;
  endfunction : read_keep_mask

endpackage : aclink_bank_pkg

`default_nettype wire

// ---- hw/aclink_codec_register_bank.sv ----
// Codec-side register bank reached over the serial audio link, shared with i2c and dsp.
// Link pins are sampled by mclk_i; the bit clock must be well below mclk_i / 4.
// What this block does
// - Bank is one RAM; i2c and dsp reads return stored word
// - ID registers: bit14 shows pin, bit15 zero
// - Other ID register bits come from RAM
// - DSP cannot read the address-select pin
// - Silence bit drives bit clock, data low
// - Warm reset clears the silence bit
// - Silence bit reads live, not RAM copy
// - Rate registers read one of two values
// - Any rate register write updates rate flag
// - Full compliance masks reserved bits on read
// - Without full compliance, reads are unmasked
// - Odd read: both slot tags valid
// - Odd read: echo address, data zero
// - Arbitrate link, i2c and dsp accesses
// - Link write stores whole word, updates mirrors
// - Link writes to vendor ID are ignored
// - Link writes to fixed rate registers store BB80h
`default_nettype none

module aclink_codec_register_bank
  import aclink_bank_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Serial link
  input wire logic bit_clk_i,
  output logic bit_clk_o,
  output logic bit_clk_oe_o,
  input wire logic sync_i,
  input wire logic sdata_out_i,
  output logic sdata_in_o,
  // Strap pins
  input wire logic address_select_pin_i,
  input wire logic input_mode_pin_i,
  // I2C port register access
  input wire logic i2c_req_i,
  input wire logic i2c_we_i,
  input wire logic [aclink_bank_pkg::IDX_W-1:0] i2c_idx_i,
  input wire logic [aclink_bank_pkg::DATA_W-1:0] i2c_wdata_i,
  output logic i2c_gnt_o,
  output logic i2c_rvalid_o,
  output logic [aclink_bank_pkg::DATA_W-1:0] i2c_rdata_o,
  // DSP register access
  input wire logic dsp_req_i,
  input wire logic dsp_we_i,
  input wire logic [aclink_bank_pkg::IDX_W-1:0] dsp_idx_i,
  input wire logic [aclink_bank_pkg::DATA_W-1:0] dsp_wdata_i,
  output logic dsp_gnt_o,
  output logic dsp_rvalid_o,
  output logic [aclink_bank_pkg::DATA_W-1:0] dsp_rdata_o,
  // Status
  output logic link_silence_bit_o,
  output logic full_compliance_sel_o
);

  import aclink_bank_pkg::*;

  localparam int WARM_W = $clog2(WARM_RESET_CYC + 1);
  localparam logic [WARM_W-1:0] WARM_CYC_C = WARM_W'(WARM_RESET_CYC);
  localparam int PIN_BCLK = 0;
  localparam int PIN_SYNC = 1;
  localparam int PIN_SDO = 2;
  localparam int PIN_SA = 3;
  localparam int PIN_MODE = 4;
  localparam int NPIN = 5;

  typedef enum {ST_IDLE, ST_REQ, ST_WAIT} link_op_t;

  typedef struct packed {
    link_op_t op;
    logic [7:0] bit_cnt;
    logic sync_prev;
    logic [SLOT_W-1:0] sh;
    logic [2:0] tag;
    logic [SLOT_W-1:0] cmd;
    logic req;
    logic we;
    reg_idx_t idx;
    word_t wdata;
    reg_addr_t rd_addr;
    logic rsp_valid;
    reg_addr_t rsp_addr;
    word_t rsp_data;
    logic out_valid;
    reg_addr_t out_addr;
    word_t out_data;
    logic sdin;
    logic [WARM_W-1:0] warm_cnt;
    logic silence;
    logic rate_flag;
    logic fc;
  } state_t;

  localparam state_t STATE_RST = '{
    op: ST_IDLE,
    silence: SILENCE_RESET,
    rate_flag: RATE_FLAG_RESET,
    fc: FULL_COMPLIANCE_RESET,
    default: '0
  };

  function automatic reg_idx_t idx_of(input reg_addr_t a);
    return a[ADDR_W-1:1];
  endfunction : idx_of

  function automatic logic is_rate_reg(input reg_addr_t a);
    return (a == ADDR_FRONT_RATE) || (a == ADDR_SURROUND_RATE) || (a == ADDR_LFE_RATE);
  endfunction : is_rate_reg

  // Link view of a stored word
  function automatic word_t read_view(input reg_addr_t a, input word_t raw, input logic sa,
                                      input logic silence, input logic rate, input logic fc);
    word_t v;
    v = raw;
    if (fc)
      v = raw & read_keep_mask(a);
    if (a == ADDR_EXT_AUDIO_CAP || a == ADDR_EXT_MODEM_CAP)
    begin
      v[CODEC_INDEX_BIT0_POS] = sa;
      v[CODEC_INDEX_BIT1_POS] = 1'b0;
    end
    if (a == ADDR_POWERDOWN)
      v[LINK_SILENCE_POS] = silence;
    if (is_rate_reg(a))
      v = rate ? RATE_44K : RATE_48K;
    return v;
  endfunction : read_view

  // Bit sent at a frame position: ready tag, slot tags, address echo, data
  function automatic logic tx_bit(input logic [7:0] pos, input logic v, input reg_addr_t a,
                                  input word_t dat);
    logic [SLOT0_W-1:0] s0;
    logic [SLOT_W-1:0] s1;
    logic [SLOT_W-1:0] s2;
    logic b;
    s0 = '0;
    s0[TAG_FRAME_POS] = 1'b1;
    s0[TAG_SLOT1_POS] = v;
    s0[TAG_SLOT2_POS] = v;
    s1 = '0;
    s1[CMD_ADDR_HI:CMD_ADDR_LO] = a;
    s2 = '0;
    s2[SLOT_W-1:DATA_LSB] = dat;
    b = 1'b0;
    if (pos <= SLOT0_LAST)
      b = s0[4'(SLOT0_LAST - pos)];
    else if (pos <= SLOT1_LAST)
      b = s1[5'(SLOT1_LAST - pos)];
    else if (pos <= SLOT2_LAST)
      b = s2[5'(SLOT2_LAST - pos)];
    return b;
  endfunction : tx_bit

  state_t q;
  state_t d;
  logic [NPIN-1:0] pin_lvl;
  logic [NPIN-1:0] pin_rise;
  logic [NPIN-1:0] pin_fall;
  logic wr_evt;
  reg_idx_t wr_idx;
  word_t wr_data;
  logic link_on;
  logic sync_lvl;
  logic bclk_edge;
  logic warm;
  logic [SLOT_W-1:0] sh_n;
  logic [7:0] pos;
  reg_addr_t cmd_addr;

  ram_port_if link_p();
  ram_port_if i2c_p();
  ram_port_if dsp_p();

  link_pin_sync #(
    .W(NPIN)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .pin_i({input_mode_pin_i, address_select_pin_i, sdata_out_i, sync_i, bit_clk_i}),
    .lvl_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  bank_ram_arbiter u_ram (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .link_p(link_p.bank),
    .i2c_p(i2c_p.bank),
    .dsp_p(dsp_p.bank),
    .wr_evt_o(wr_evt),
    .wr_idx_o(wr_idx),
    .wr_data_o(wr_data)
  );

  assign link_on = pin_lvl[PIN_MODE];
  assign sync_lvl = pin_lvl[PIN_SYNC];
  assign bclk_edge = pin_rise[PIN_BCLK] | pin_fall[PIN_BCLK];

  always_comb
  begin
    d = q;
    sh_n = {q.sh[SLOT_W-2:0], pin_lvl[PIN_SDO]};
    pos = q.bit_cnt;
    cmd_addr = q.cmd[CMD_ADDR_HI:CMD_ADDR_LO];

    // Warm reset: sync high while the bit clock stands still
    if (!sync_lvl || bclk_edge || !link_on)
      d.warm_cnt = '0;
    else if (q.warm_cnt != WARM_CYC_C)
      d.warm_cnt = WARM_W'(q.warm_cnt + 1'b1);
    warm = (d.warm_cnt == WARM_CYC_C) && (q.warm_cnt != WARM_CYC_C);
    if (warm)
      d.silence = SILENCE_RESET;

    // Mirrors follow every committed write; applied after warm reset so a write wins
    if (wr_evt)
    begin
      if (wr_idx == idx_of(ADDR_SW_RESET))
      begin
        d.silence = SILENCE_RESET;
        d.rate_flag = RATE_FLAG_RESET;
        d.fc = FULL_COMPLIANCE_RESET;
      end
      else if (wr_idx == idx_of(ADDR_POWERDOWN))
        d.silence = wr_data[LINK_SILENCE_POS];
      else if (wr_idx == idx_of(ADDR_FRONT_RATE) || wr_idx == idx_of(ADDR_SURROUND_RATE)
               || wr_idx == idx_of(ADDR_LFE_RATE))
        d.rate_flag = (wr_data == RATE_44K);
      else if (wr_idx == idx_of(ADDR_VENDOR_CFG))
        d.fc = wr_data[FULL_COMPLIANCE_POS];
    end

    // RAM access sequencing; the request stays up until granted
    case (q.op)
      ST_REQ:
      begin
        if (link_p.gnt)
        begin
          d.req = 1'b0;
          d.op = q.we ? ST_IDLE : ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (link_p.rvalid)
        begin
          d.rsp_valid = 1'b1;
          d.rsp_addr = q.rd_addr;
          d.rsp_data = read_view(q.rd_addr, link_p.rdata, pin_lvl[PIN_SA], q.silence, q.rate_flag, q.fc);
          d.op = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        d.op = ST_IDLE;
      end
      default:
      begin
        d.op = ST_IDLE;
      end
    endcase

    // Receive: sample on the falling edge of the bit clock
    if (link_on && pin_fall[PIN_BCLK])
    begin
      d.sh = sh_n;
      d.sync_prev = sync_lvl;
      if (sync_lvl && !q.sync_prev)
      begin
        d.bit_cnt = '0;
        d.out_valid = q.rsp_valid;
        d.out_addr = q.rsp_addr;
        d.out_data = q.rsp_data;
        d.rsp_valid = 1'b0;
      end
      else
        d.bit_cnt = 8'(q.bit_cnt + 8'h01);
      pos = d.bit_cnt;
      if (pos == SLOT0_LAST)
        d.tag = sh_n[TAG_FRAME_POS:TAG_SLOT2_POS];
      if (pos == SLOT1_LAST)
        d.cmd = sh_n;
      if (pos == SLOT2_LAST && q.tag[2] && q.tag[1] && q.op == ST_IDLE)
      begin
        if (q.cmd[CMD_READ_POS])
        begin
          if (cmd_addr[0])
          begin
            d.rsp_valid = 1'b1;
            d.rsp_addr = cmd_addr;
            d.rsp_data = '0;
          end
          else
          begin
            d.req = 1'b1;
            d.we = 1'b0;
            d.idx = idx_of(cmd_addr);
            d.rd_addr = cmd_addr;
            d.op = ST_REQ;
          end
        end
        else if (q.tag[0] && !cmd_addr[0] && cmd_addr != ADDR_VENDOR_ID1 && cmd_addr != ADDR_VENDOR_ID2)
        begin
          d.req = 1'b1;
          d.we = 1'b1;
          d.idx = idx_of(cmd_addr);
          if (cmd_addr == ADDR_FIXED_RATE0 || cmd_addr == ADDR_FIXED_RATE1)
            d.wdata = RATE_48K;
          else
            d.wdata = sh_n[SLOT_W-1:DATA_LSB];
          d.op = ST_REQ;
        end
      end
    end

    // Transmit: drive the next position on the rising edge of the bit clock
    if (q.silence || !link_on)
      d.sdin = 1'b0;
    else if (pin_rise[PIN_BCLK])
      d.sdin = tx_bit(8'(q.bit_cnt + 8'h01), q.out_valid, q.out_addr, q.out_data);
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      q <= STATE_RST;
    else
      q <= d;
  end

  assign link_p.req = q.req;
  assign link_p.we = q.we;
  assign link_p.idx = q.idx;
  assign link_p.wdata = q.wdata;

  assign i2c_p.req = i2c_req_i;
  assign i2c_p.we = i2c_we_i;
  assign i2c_p.idx = i2c_idx_i;
  assign i2c_p.wdata = i2c_wdata_i;
  assign i2c_gnt_o = i2c_p.gnt;
  assign i2c_rvalid_o = i2c_p.rvalid;
  assign i2c_rdata_o = i2c_p.rdata;

  assign dsp_p.req = dsp_req_i;
  assign dsp_p.we = dsp_we_i;
  assign dsp_p.idx = dsp_idx_i;
  assign dsp_p.wdata = dsp_wdata_i;
  assign dsp_gnt_o = dsp_p.gnt;
  assign dsp_rvalid_o = dsp_p.rvalid;
  // Raw RAM word only; the pin never reaches this path
  assign dsp_rdata_o = dsp_p.rdata;

  // Bit clock held low by driving the pin while silenced
  assign bit_clk_o = 1'b0;
  assign bit_clk_oe_o = q.silence;
  assign sdata_in_o = q.sdin;
  assign link_silence_bit_o = q.silence;
  assign full_compliance_sel_o = q.fc;

endmodule : aclink_codec_register_bank

`default_nettype wire

// ---- hw/bank_ram_arbiter.sv ----
// Shared register RAM with a fixed-priority arbiter for three requesters.
// Port order sets priority: link first, then i2c, then dsp; one access a cycle.
`default_nettype none

module bank_ram_arbiter
  import aclink_bank_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Requesters
  ram_port_if.bank link_p,
  ram_port_if.bank i2c_p,
  ram_port_if.bank dsp_p,
  // Committed write, for mirrored flip-flops
  output logic wr_evt_o,
  output reg_idx_t wr_idx_o,
  output word_t wr_data_o
);

  localparam int NREQ = 3;

  typedef struct packed {
    logic [NREQ-1:0] rvalid;
    word_t rdata;
    logic wr_evt;
    reg_idx_t wr_idx;
    word_t wr_data;
  } arb_state_t;

  arb_state_t q;
  arb_state_t d;
  word_t mem [RAM_WORDS];
  logic [NREQ-1:0] req;
  logic [NREQ-1:0] we;
  logic [NREQ-1:0] gnt;
  reg_idx_t idx [NREQ];
  word_t wdata [NREQ];
  reg_idx_t sel_idx;
  word_t sel_wdata;
  logic sel_we;
  logic any_gnt;

  assign req = {dsp_p.req, i2c_p.req, link_p.req};
  assign we = {dsp_p.we, i2c_p.we, link_p.we};
  assign idx[0] = link_p.idx;
  assign idx[1] = i2c_p.idx;
  assign idx[2] = dsp_p.idx;
  assign wdata[0] = link_p.wdata;
  assign wdata[1] = i2c_p.wdata;
  assign wdata[2] = dsp_p.wdata;

  always_comb
  begin
    gnt = '0;
    sel_idx = '0;
    sel_wdata = '0;
    sel_we = 1'b0;
    any_gnt = 1'b0;
    for (int i = 0; i < NREQ; i++)
    begin
      if (req[i] && !any_gnt)
      begin
        gnt[i] = 1'b1;
        any_gnt = 1'b1;
        sel_idx = idx[i];
        sel_wdata = wdata[i];
        sel_we = we[i];
      end
    end
  end

  always_comb
  begin
    d = q;
    d.rvalid = gnt & ~we;
    d.rdata = any_gnt && !sel_we ? mem[sel_idx] : q.rdata;
    d.wr_evt = any_gnt && sel_we;
    d.wr_idx = sel_idx;
    d.wr_data = sel_wdata;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      q <= '0;
    else
      q <= d;
  end

  // Whole word stored, reserved bits included
  always_ff @(posedge mclk_i)
  begin
    if (any_gnt && sel_we)
      mem[sel_idx] <= sel_wdata;
  end

  assign link_p.gnt = gnt[0];
  assign i2c_p.gnt = gnt[1];
  assign dsp_p.gnt = gnt[2];
  assign link_p.rvalid = q.rvalid[0];
  assign i2c_p.rvalid = q.rvalid[1];
  assign dsp_p.rvalid = q.rvalid[2];
  assign link_p.rdata = q.rdata;
  assign i2c_p.rdata = q.rdata;
  assign dsp_p.rdata = q.rdata;
  assign wr_evt_o = q.wr_evt;
  assign wr_idx_o = q.wr_idx;
  assign wr_data_o = q.wr_data;

endmodule : bank_ram_arbiter

`default_nettype wire

// ---- hw/link_pin_sync.sv ----
// Two-flop synchroniser for pins from outside the clock domain, with edge pulses.
// Edges are taken between the second and third flop only.
`default_nettype none

module link_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Pins in, synchronised view out
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] lvl_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb
  begin
    d = q;
    d.meta = pin_i;
    d.stable = q.meta;
    d.prev = q.stable;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      q <= '0;
    else
      q <= d;
  end

  assign lvl_o = q.stable;
  assign rise_o = q.stable & ~q.prev;
  assign fall_o = ~q.stable & q.prev;

endmodule : link_pin_sync

`default_nettype wire

// ---- hw/ram_port_if.sv ----
// One requester's access port into the shared register RAM.
// Request is held until grant; read data follows one cycle after grant.
`default_nettype none

interface ram_port_if;
  import aclink_bank_pkg::*;
  logic req;
  logic we;
  reg_idx_t idx;
  word_t wdata;
  logic gnt;
  logic rvalid;
  word_t rdata;
  modport client(output req, output we, output idx, output wdata, input gnt, input rvalid, input rdata);
  modport bank(input req, input we, input idx, input wdata, output gnt, output rvalid, output rdata);
endinterface : ram_port_if

`default_nettype wire

// ---- verification/aclink_bank_monitor.sv ----
// Port monitor of the register bank: arbitration, read timing, mirrored flops.
// Sees only top-level ports; one clock domain.
`default_nettype none

module aclink_bank_monitor
  import aclink_bank_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Link and strap
  input wire logic bit_clk_o,
  input wire logic bit_clk_oe_o,
  input wire logic sdata_in_o,
  input wire logic input_mode_pin_i,
  // Register ports
  input wire logic i2c_req_i,
  input wire logic i2c_we_i,
  input wire logic [aclink_bank_pkg::IDX_W-1:0] i2c_idx_i,
  input wire logic [aclink_bank_pkg::DATA_W-1:0] i2c_wdata_i,
  input wire logic i2c_gnt_o,
  input wire logic i2c_rvalid_o,
  input wire logic dsp_req_i,
  input wire logic dsp_we_i,
  input wire logic [aclink_bank_pkg::IDX_W-1:0] dsp_idx_i,
  input wire logic dsp_gnt_o,
  input wire logic dsp_rvalid_o,
  // Status
  input wire logic link_silence_bit_o,
  input wire logic full_compliance_sel_o
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence i2c_rd_s;
    i2c_req_i && i2c_gnt_o && !i2c_we_i;
  endsequence
  sequence dsp_rd_s;
    dsp_req_i && dsp_gnt_o && !dsp_we_i;
  endsequence
  sequence reg0_wr_s;
    (i2c_req_i && i2c_gnt_o && i2c_we_i && i2c_idx_i == 6'h00) || (dsp_req_i && dsp_gnt_o && dsp_we_i && dsp_idx_i == 6'h00);
  endsequence

  chk_clk_held: assert property (!bit_clk_o) else $error("bit clock output not low");
  chk_silence_out: assert property (link_silence_bit_o [*3] |-> bit_clk_oe_o && !sdata_in_o)
    else $error("silenced link still active");
  chk_link_free: assert property (!link_silence_bit_o [*3] |-> !bit_clk_oe_o) else $error("bit clock held");
  chk_grant_prio: assert property (i2c_req_i && dsp_req_i |-> !dsp_gnt_o) else $error("dsp beat i2c");
  chk_grant_one: assert property (!(i2c_gnt_o && dsp_gnt_o)) else $error("two grants");
  chk_i2c_rvalid: assert property (i2c_rd_s |=> i2c_rvalid_o) else $error("i2c rvalid missing");
  chk_dsp_rvalid: assert property (dsp_rd_s |=> dsp_rvalid_o) else $error("dsp rvalid missing");
  chk_rvalid_cause: assert property (i2c_rvalid_o |-> $past(i2c_gnt_o) && !$past(i2c_we_i))
    else $error("stray i2c rvalid");
  chk_sw_reset: assert property (reg0_wr_s |=> ##[0:2] full_compliance_sel_o && !link_silence_bit_o)
    else $error("mirrors kept after reset write");
  chk_silence_clr: assert property (i2c_req_i && i2c_gnt_o && i2c_we_i && i2c_idx_i == 6'h13
    && !i2c_wdata_i[LINK_SILENCE_POS] |=> ##[0:2] !link_silence_bit_o) else $error("silence not cleared");
  chk_mode_off: assert property (!input_mode_pin_i [*4] |-> !sdata_in_o) else $error("link active");

endmodule : aclink_bank_monitor

`default_nettype wire

// ---- verification/aclink_ctl_model.sv ----
// Controller end of the serial audio link: command frames and warm reset.
// Frames are started by the bench just after an mclk rising edge.
`default_nettype none

module aclink_ctl_model (
  // Link pins
  output logic bclk_o,
  output logic sync_o,
  output logic sdo_o,
  input wire logic sdi_i
);
  timeunit 1ns;
  timeprecision 1ns;

  // Full-length frame, so the codec's position count wraps to zero at the next frame start
  localparam int FRAME_BITS = 256;
  localparam int USED_BITS = 56;

  initial
  begin
    bclk_o = 1'b0;
    sync_o = 1'b0;
    sdo_o = 1'b0;
  end

  // Bit driven on the rise, reply taken on the fall; clock stands still afterwards
  task automatic frame(input logic [0:55] tx, output logic [0:55] rx);
    for (int p = 0; p < FRAME_BITS; p++)
    begin
      bclk_o = 1'b1;
      sync_o = (p < 16);
      sdo_o = (p < USED_BITS) ? tx[p] : 1'b0;
      #200;
      if (p < USED_BITS)
        rx[p] = sdi_i;
      bclk_o = 1'b0;
      #200;
    end
    sync_o = 1'b0;
    sdo_o = ~sdo_o;
  endtask : frame

  // Sync held high with no clock edge
  task automatic warm_reset();
    sync_o = 1'b1;
    #1200;
    sync_o = 1'b0;
  endtask : warm_reset

endmodule : aclink_ctl_model

`default_nettype wire

// ---- verification/test_aclink_codec_register_bank.sv ----
// Self-checking bench of the register bank: link frames plus i2c and dsp ports.
// Uses the link controller model; the port monitor is bound below.
`default_nettype none

module test_aclink_codec_register_bank;
  timeunit 1ns;
  timeprecision 1ns;
  import aclink_bank_pkg::*;

  logic mclk, rst_n, asel, mode, ir, iw, dr, dw, ig, iv, dg, dv;
  logic cbclk, sync, sdo, sdi, bclk_o, bclk_oe, silence, fc;
  reg_idx_t ii, di;
  word_t iwd, dwd, ird, drd;
  int n_mismatch = 0;
  int check_count = 0;
  // Bit clock wire: the device pulls it low while silenced
  wire logic bclk = bclk_oe ? bclk_o : cbclk;

  aclink_codec_register_bank dut (
    .mclk_i(mclk), .arst_n_i(rst_n), .bit_clk_i(bclk), .bit_clk_o(bclk_o), .bit_clk_oe_o(bclk_oe),
    .sync_i(sync), .sdata_out_i(sdo), .sdata_in_o(sdi), .address_select_pin_i(asel), .input_mode_pin_i(mode),
    .i2c_req_i(ir), .i2c_we_i(iw), .i2c_idx_i(ii), .i2c_wdata_i(iwd), .i2c_gnt_o(ig), .i2c_rvalid_o(iv),
    .i2c_rdata_o(ird), .dsp_req_i(dr), .dsp_we_i(dw), .dsp_idx_i(di), .dsp_wdata_i(dwd), .dsp_gnt_o(dg),
    .dsp_rvalid_o(dv), .dsp_rdata_o(drd), .link_silence_bit_o(silence), .full_compliance_sel_o(fc)
  );
  aclink_ctl_model ctl (.bclk_o(cbclk), .sync_o(sync), .sdo_o(sdo), .sdi_i(sdi));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input string what, input word_t exp, input word_t got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One access on the i2c (d=0) or dsp (d=1) port, request held until granted
  task automatic acc(input logic d, input logic we, input reg_idx_t ix, input word_t wd, output word_t rd);
    logic g;
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    if (d) {dr, dw, di, dwd} = {1'b1, we, ix, wd};
    else {ir, iw, ii, iwd} = {1'b1, we, ix, wd};
    do
    begin
      @(negedge mclk);
      g = d ? dg : ig;
      @(posedge mclk);
      n++;
    end
    while (g !== 1'b1 && n < 40);
    #1;
    if (d) dr = 1'b0;
    else ir = 1'b0;
    @(negedge mclk);
    rd = d ? drd : ird;
    check("grant", 16'h1, {15'h0, g});
    if (!we) check("rvalid", 16'h1, {15'h0, d ? dv : iv});
  endtask : acc

  task automatic lnk(input logic rd, input reg_addr_t a, input word_t wd, output logic [0:55] rx);
    logic [0:55] tx;
    tx = '0;
    tx[0:2] = {2'b11, !rd};
    tx[16:23] = {rd, a};
    tx[36:51] = wd;
    @(posedge mclk);
    #1;
    ctl.frame(tx, rx);
    repeat (4) @(posedge mclk);
  endtask : lnk

  // Link read; the reply comes in the following frame
  task automatic lrd(input reg_addr_t a, input word_t exp);
    logic [0:55] rx;
    lnk(1'b1, a, 16'h0, rx);
    @(posedge mclk);
    #1;
    ctl.frame('0, rx);
    check("tags", 16'h7, {13'h0, rx[0:2]});
    check("echo", {9'h0, a}, {9'h0, rx[17:23]});
    check("rdata", exp, rx[36:51]);
  endtask : lrd

  task automatic final_report();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  initial
  begin
    #(60000 * 50);
    n_mismatch++;
    final_report();
  end

  initial
  begin
    word_t rd, rd2;
    logic [0:55] rx;
    rst_n = 1'b0;
    mode = 1'b1;
    asel = 1'b1;
    {ir, iw, dr, dw, ii, di, iwd, dwd} = '0;
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    check("silence", 16'h0, {15'h0, silence});
    check("fc", 16'h1, {15'h0, fc});
    acc(1'b0, 1'b1, 6'h14, 16'hBFFF, rd);
    acc(1'b0, 1'b1, 6'h1E, 16'hBFFF, rd);
    acc(1'b1, 1'b0, 6'h14, 16'h0, rd);
    check("dsp 28h", 16'hBFFF, rd);
    lrd(7'h28, 16'h4FFF);
    asel = 1'b0;
    lrd(7'h3C, 16'h0FFF);
    fork
      acc(1'b0, 1'b1, 6'h20, 16'h1234, rd);
      acc(1'b1, 1'b0, 6'h20, 16'h0, rd2);
    join
    check("dsp after i2c", 16'h1234, rd2);
    lrd(7'h40, 16'h1234);
    lrd(7'h29, 16'h0);
    lnk(1'b0, 7'h2C, 16'hAC44, rx);
    lrd(7'h2E, 16'hAC44);
    acc(1'b0, 1'b1, 6'h18, 16'h1234, rd);
    lrd(7'h30, 16'hBB80);
    lnk(1'b0, 7'h32, 16'h1234, rx);
    acc(1'b0, 1'b0, 6'h19, 16'h0, rd);
    check("fixed rate", 16'hBB80, rd);
    acc(1'b0, 1'b1, 6'h3E, 16'h5A5A, rd);
    lnk(1'b0, 7'h7C, 16'h1111, rx);
    acc(1'b0, 1'b0, 6'h3E, 16'h0, rd);
    check("vendor id", 16'h5A5A, rd);
    lnk(1'b0, 7'h6A, 16'h0, rx);
    check("fc off", 16'h0, {15'h0, fc});
    #1 asel = 1'b1;
    lrd(7'h28, 16'h7FFF);
    acc(1'b1, 1'b1, 6'h00, 16'h0, rd);
    repeat (3) @(posedge mclk);
    check("fc back", 16'h1, {15'h0, fc});
    lnk(1'b0, 7'h26, 16'h1000, rx);
    check("silence", 16'h1, {15'h0, silence});
    check("bclk oe", 16'h1, {15'h0, bclk_oe});
    check("sdata in", 16'h0, {15'h0, sdi});
    acc(1'b0, 1'b1, 6'h13, 16'h0, rd);
    acc(1'b0, 1'b1, 6'h13, 16'h1000, rd);
    repeat (3) @(posedge mclk);
    check("silence set", 16'h1, {15'h0, silence});
    #1;
    ctl.warm_reset();
    repeat (3) @(posedge mclk);
    check("warm reset", 16'h0, {15'h0, silence});
    lrd(7'h26, 16'h0000);
    acc(1'b0, 1'b0, 6'h13, 16'h0, rd);
    check("ram 26h", 16'h1000, rd);
    @(posedge mclk);
    #1 mode = 1'b0;
    repeat (10) @(posedge mclk);
    final_report();
  end

endmodule : test_aclink_codec_register_bank

bind aclink_codec_register_bank aclink_bank_monitor mon (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .bit_clk_o(bit_clk_o), .bit_clk_oe_o(bit_clk_oe_o),
  .sdata_in_o(sdata_in_o), .input_mode_pin_i(input_mode_pin_i), .i2c_req_i(i2c_req_i), .i2c_we_i(i2c_we_i),
  .i2c_idx_i(i2c_idx_i), .i2c_wdata_i(i2c_wdata_i), .i2c_gnt_o(i2c_gnt_o), .i2c_rvalid_o(i2c_rvalid_o),
  .dsp_req_i(dsp_req_i), .dsp_we_i(dsp_we_i), .dsp_idx_i(dsp_idx_i), .dsp_gnt_o(dsp_gnt_o),
  .dsp_rvalid_o(dsp_rvalid_o), .link_silence_bit_o(link_silence_bit_o), .full_compliance_sel_o(full_compliance_sel_o)
);

`default_nettype wire
